// ---- logic/acs_sequencer.sv ----
// Purpose: calibration sequencer and result correction of a sigma-delta converter
// Assumes: all inputs are synchronous to clk; raw.valid is one-cycle pulse
// Notes:   the filter is expected to deliver its next result from the newly
//          selected input after each filter_rst pulse
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_sequencer #(
    parameter int SETTLE_CONV = `ACS_SETTLE_CONV
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 mode_wr,
    input  wire logic                 cal_mode_bit2,
    input  wire logic                 cal_mode_bit1,
    input  wire logic                 cal_mode_bit0,
    input  wire logic                 bipolar,
    input  wire logic                 long_word,
    input  wire logic [2:0]           pga_gain,
    input  wire acs_pkg::acs_raw_s     raw,
    input  wire logic                 result_read,
    input  wire acs_pkg::acs_coef_wr_s ofs_wr,
    input  wire acs_pkg::acs_coef_wr_s fs_wr,
    output acs_pkg::acs_sel_e          in_sel_ff,
    output logic [2:0]                gain_sel_ff,
    output logic                      filter_rst_ff,
    output acs_pkg::acs_result_s       result_ff,
    output logic                      result_ready_n_ff,
    output logic [23:0]               ofs_coef_ff,
    output logic [23:0]               fs_coef_ff
);

    // the settle counter is three bits wide
    generate
        if (SETTLE_CONV < 1 || SETTLE_CONV > 7) begin : g_chk
            $error("SETTLE_CONV must lie in 1..7");
        end
    endgenerate

    localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CONV - 1);

    // codes that name a calibration; others start none, but end background mode
    function automatic logic fn_is_cal(input logic [2:0] c);
        return (c >= `ACS_CODE_SELF) && (c <= `ACS_CODE_BACKGND);
    endfunction

    // input selection for a state; used for the mux and its change detect
    function automatic acs_pkg::acs_sel_e fn_sel(
        input acs_pkg::acs_state_e st,
        input logic [2:0]          kind,
        input logic [2:0]          slot
    );
        acs_pkg::acs_sel_e s;
        s = acs_pkg::SEL_ANALOG;
        if (st == acs_pkg::ST_ZERO) begin
            if (kind == `ACS_CODE_SELF) begin
                s = acs_pkg::SEL_SHORT;
            end
        end else if (st == acs_pkg::ST_FULL) begin
            if (kind != `ACS_CODE_SYS_FULL) begin
                s = acs_pkg::SEL_REF;
            end
        end else if (st == acs_pkg::ST_BG) begin
            if (slot == 3'h0) begin
                s = acs_pkg::SEL_SHORT;
            end else if (slot == 3'h1) begin
                s = acs_pkg::SEL_REF;
            end
        end
        return s;
    endfunction

    acs_pkg::acs_state_e state_ff;
    logic [2:0]          kind_ff;
    logic [2:0]          slot_ff;
    logic [2:0]          settle_cnt_ff;
    logic                bg_first_ff;
    logic signed [23:0]  zero_ff;
    logic signed [23:0]  full_ff;
    logic                div_go_ff;
    logic                div_busy_ff;
    logic                div_done_ff;
    logic                div_ok_ff;
    logic [5:0]          div_cnt_ff;
    logic [24:0]         dvs_ff;
    logic [24:0]         rem_ff;
    logic [47:0]         num_ff;
    logic [47:0]         quo_ff;

    logic [2:0]          mode_code;
    logic                start_cal;
    logic                bg_on;
    logic                new_res;
    acs_pkg::acs_sel_e    sel_now;

    assign mode_code = {cal_mode_bit2, cal_mode_bit1, cal_mode_bit0};
    assign bg_on     = (state_ff == acs_pkg::ST_BG);
    // rewriting the background code while in background is no new command
    assign start_cal = mode_wr && fn_is_cal(mode_code) &&
                       !(bg_on && mode_code == `ACS_CODE_BACKGND);
    assign sel_now   = fn_sel(state_ff, kind_ff, slot_ff);

    // sequencer state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= acs_pkg::ST_IDLE;
            kind_ff  <= `ACS_CODE_NORMAL;
        end else if (start_cal) begin
            kind_ff <= mode_code;
            if (mode_code == `ACS_CODE_SYS_FULL) begin
                state_ff <= acs_pkg::ST_FULL;
            end else if (mode_code == `ACS_CODE_BACKGND) begin
                state_ff <= acs_pkg::ST_BG;
            end else begin
                state_ff <= acs_pkg::ST_ZERO;
            end
        end else if (mode_wr && bg_on && mode_code != `ACS_CODE_BACKGND) begin
            state_ff <= acs_pkg::ST_IDLE;
        end else begin
            unique case (state_ff)
                acs_pkg::ST_ZERO: begin
                    if (raw.valid) begin
                        // system zero alone stops after the offset point
                        state_ff <= (kind_ff == `ACS_CODE_SYS_ZERO) ?
                                    acs_pkg::ST_SETTLE : acs_pkg::ST_FULL;
                    end
                end
                acs_pkg::ST_FULL: begin
                    if (raw.valid) begin
                        state_ff <= acs_pkg::ST_DIV;
                    end
                end
                acs_pkg::ST_DIV: begin
                    if (div_done_ff) begin
                        state_ff <= acs_pkg::ST_SETTLE;
                    end
                end
                acs_pkg::ST_SETTLE: begin
                    if (raw.valid && settle_cnt_ff == SETTLE_LAST) begin
                        state_ff <= acs_pkg::ST_IDLE;
                    end
                end
                acs_pkg::ST_IDLE, acs_pkg::ST_BG: begin
                    state_ff <= state_ff;
                end
            endcase
        end
    end

    // gain latched at command so the cal runs at the selected gain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_sel_ff <= 3'h0;
        end else if (start_cal || state_ff == acs_pkg::ST_IDLE) begin
            gain_sel_ff <= pga_gain;
        end
    end

    // input mux; a filter reset on each command and on each switch
    // keeps stale samples of the old input out of the next result
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_sel_ff     <= acs_pkg::SEL_ANALOG;
            filter_rst_ff <= 1'b0;
        end else begin
            in_sel_ff     <= sel_now;
            filter_rst_ff <= start_cal || (sel_now != in_sel_ff);
        end
    end

    // resettle count after the coefficients are in place
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settle_cnt_ff <= 3'h0;
        end else if (state_ff != acs_pkg::ST_SETTLE || start_cal) begin
            settle_cnt_ff <= 3'h0;
        end else if (raw.valid) begin
            settle_cnt_ff <= settle_cnt_ff + 3'h1;
        end
    end

    // background slots: shorted, reference, then four on the input;
    // one output per six results, filter bandwidth is untouched
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot_ff <= 3'h0;
        end else if (!bg_on || start_cal) begin
            slot_ff <= 3'h0;
        end else if (raw.valid) begin
            slot_ff <= (slot_ff == `ACS_BG_LAST) ? 3'h0 : slot_ff + 3'h1;
        end
    end

    // first background output follows only the frame's first full-scale pass
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bg_first_ff <= 1'b0;
        end else if (start_cal) begin
            bg_first_ff <= (mode_code == `ACS_CODE_BACKGND);
        end else if (new_res) begin
            bg_first_ff <= 1'b0;
        end
    end

    // capture of the two calibration conversions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            zero_ff <= 24'sh000000;
            full_ff <= 24'sh000000;
        end else if (raw.valid) begin
            if (state_ff == acs_pkg::ST_ZERO ||
                (bg_on && slot_ff == 3'h0)) begin
                zero_ff <= raw.data;
            end
            if (state_ff == acs_pkg::ST_FULL ||
                (bg_on && slot_ff == 3'h1)) begin
                full_ff <= raw.data;
            end
        end
    end

    // divide starts a cycle after capture so full_ff is settled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_go_ff <= 1'b0;
        end else begin
            div_go_ff <= raw.valid && !start_cal &&
                         ((state_ff == acs_pkg::ST_FULL) ||
                          (bg_on && slot_ff == 3'h1));
        end
    end

    logic signed [24:0] span;
    logic [24:0]        target;
    logic [25:0]        rem_sh;
    logic               rem_ge;

    // full-scale against zero conversion, or against the stored offset
    assign span   = (kind_ff == `ACS_CODE_SYS_FULL) ?
                    25'(full_ff) - 25'($signed(ofs_coef_ff)) :
                    25'(full_ff) - 25'(zero_ff);
    assign target = bipolar ? `ACS_TGT_BIP : `ACS_TGT_UNI;
    assign rem_sh = {rem_ff, num_ff[47]};
    assign rem_ge = rem_sh >= {1'b0, dvs_ff};

    // bit-serial divider: slope = target span / measured span
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_busy_ff <= 1'b0;
            div_done_ff <= 1'b0;
            div_ok_ff   <= 1'b0;
            div_cnt_ff  <= 6'h00;
            dvs_ff      <= 25'h0000000;
            rem_ff      <= 25'h0000000;
            num_ff      <= 48'h000000000000;
            quo_ff      <= 48'h000000000000;
        end else if (div_go_ff) begin
            // a span at or below zero cannot give a slope; keep the old one
            div_ok_ff   <= (span > 25'sh0000000);
            div_busy_ff <= (span > 25'sh0000000);
            div_done_ff <= !(span > 25'sh0000000);
            div_cnt_ff  <= 6'h00;
            dvs_ff      <= span;
            rem_ff      <= 25'h0000000;
            num_ff      <= {1'b0, target, {`ACS_FRAC{1'b0}}};
            quo_ff      <= 48'h000000000000;
        end else if (div_busy_ff) begin
            rem_ff      <= rem_ge ? 25'(rem_sh - {1'b0, dvs_ff}) : rem_sh[24:0];
            num_ff      <= {num_ff[46:0], 1'b0};
            quo_ff      <= {quo_ff[46:0], rem_ge};
            div_cnt_ff  <= div_cnt_ff + 6'h01;
            div_busy_ff <= (div_cnt_ff != `ACS_DIV_LAST);
            div_done_ff <= (div_cnt_ff == `ACS_DIV_LAST);
        end else begin
            div_done_ff <= 1'b0;
        end
    end

    // coefficients: host writes, then calibration results override
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ofs_coef_ff <= `ACS_OFS_RST;
            fs_coef_ff  <= `ACS_FS_RST;
        end else begin
            if (ofs_wr.wr) begin
                ofs_coef_ff <= ofs_wr.data;
            end
            if (fs_wr.wr) begin
                fs_coef_ff <= fs_wr.data;
            end
            if (state_ff == acs_pkg::ST_ZERO && raw.valid && !start_cal &&
                kind_ff == `ACS_CODE_SYS_ZERO) begin
                ofs_coef_ff <= raw.data;
            end
            if (div_done_ff && div_ok_ff) begin
                fs_coef_ff <= (|quo_ff[47:24]) ? 24'hFFFFFF : quo_ff[23:0];
                if (kind_ff != `ACS_CODE_SYS_FULL) begin
                    ofs_coef_ff <= zero_ff;
                end
            end
        end
    end

    logic signed [32:0] diff;
    logic signed [57:0] prod;
    logic signed [32:0] scaled;
    logic signed [32:0] coded;
    logic [23:0]        code24;
    logic [23:0]        word;

    // offset first, then slope, all on the wide accumulator
    assign diff   = `ACS_ACC_W'(raw.data) - `ACS_ACC_W'($signed(ofs_coef_ff));
    assign prod   = diff * $signed({1'b0, fs_coef_ff});
    assign scaled = 33'(prod >>> `ACS_FRAC);
    assign coded  = bipolar ? scaled + $signed(`ACS_MID) : scaled;

    // clamp to the output code range rather than wrap
    always_comb begin
        if (coded < 33'sh000000000) begin
            code24 = 24'h000000;
        end else if (coded > $signed(`ACS_CODE_MAX)) begin
            code24 = 24'hFFFFFF;
        end else begin
            code24 = coded[23:0];
        end
        word = long_word ? code24 : {8'h00, code24[23:8]};
    end

    // results go out when idle, at the end of a settle, or once per bg frame
    assign new_res = raw.valid && !start_cal &&
                     ((state_ff == acs_pkg::ST_IDLE) ||
                      (state_ff == acs_pkg::ST_SETTLE &&
                       settle_cnt_ff == SETTLE_LAST) ||
                      (bg_on && slot_ff == `ACS_BG_LAST));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_ff <= '0;
        end else if (new_res) begin
            result_ff.data  <= word;
            result_ff.stale <= bg_on && bg_first_ff;
        end
    end

    // ready: a new result beats a read in the same cycle; a command
    // raises it on the next edge, well inside one modulator cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_ready_n_ff <= 1'b1;
        end else if (new_res) begin
            result_ready_n_ff <= 1'b0;
        end else if (start_cal) begin
            result_ready_n_ff <= 1'b1;
        end else if (result_read) begin
            result_ready_n_ff <= 1'b1;
        end
    end

endmodule

// ---- common/acs_params.svh ----
// Purpose: constants of the calibration sequencer
// Assumes: included by the sequencer module, its monitor and its bench
// Notes:   codes, widths, reset values and counts live here only
// Functional notes
// - self-cal converts shorted node then reference, derives zero and full-scale coefficients
// - self-cal ready only after both conversions, coefficient update and filter resettle
// - bipolar self-cal calibrates midscale to positive full scale
// - self-cal runs with the selected gain applied
// - system zero code converts analog input as zero point; ready low after
// - system full code converts analog input as full-scale point; ready low after
// - repeating system zero step updates offset, keeps slope
// - system cals span endpoints unipolar, midscale to plus full scale bipolar
// - system offset cal: zero from analog input, span against reference, one step
// - background code interleaves shorted and reference conversions, updating coefficients
// - background mode cuts output rate by six, bandwidth unchanged
// - background stays active until the mode field changes
// - first background result flagged invalid; later updates settled
// - result has offset subtracted, then multiplied by full-scale coefficient
// - correction arithmetic is 33 bits wide; output 16 or 24 bits
// - self, system and offset cals signal completion by ready going low
// - ready goes high within one modulator cycle of a calibration command
// - host-written offset and full-scale coefficients set offset and span
// - every calibration command resets the digital filter
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_CODE_NORMAL   3'h0
`define ACS_CODE_SELF     3'h1
`define ACS_CODE_SYS_ZERO 3'h2
`define ACS_CODE_SYS_FULL 3'h3
`define ACS_CODE_SYS_OFS  3'h4
`define ACS_CODE_BACKGND  3'h5
`define ACS_ACC_W         33
`define ACS_FRAC          22
`define ACS_OFS_RST       24'h000000
`define ACS_FS_RST        24'h400000
`define ACS_TGT_UNI       25'h1000000
`define ACS_TGT_BIP       25'h0800000
`define ACS_MID           33'h000800000
`define ACS_CODE_MAX      33'h000FFFFFF
`define ACS_BG_LAST       3'h5
`define ACS_DIV_LAST      6'h2F
`define ACS_SETTLE_CONV   3
`endif

// ---- common/acs_pkg.sv ----
// Purpose: types shared by the calibration sequencer and its bench
// Assumes: constants come from acs_params.svh
// Notes:   one-hot state codes are written out
package acs_pkg;
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ZERO   = 6'h02,
        ST_FULL   = 6'h04,
        ST_DIV    = 6'h08,
        ST_SETTLE = 6'h10,
        ST_BG     = 6'h20
    } acs_state_e;

    typedef enum logic [1:0] {
        SEL_ANALOG = 2'h0,
        SEL_SHORT  = 2'h1,
        SEL_REF    = 2'h2
    } acs_sel_e;

    // one filter result, two's complement around modulator zero
    typedef struct packed {
        logic               valid;
        logic signed [23:0] data;
    } acs_raw_s;

    typedef struct packed {
        logic        wr;
        logic [23:0] data;
    } acs_coef_wr_s;

    typedef struct packed {
        logic [23:0] data;
        logic        stale;
    } acs_result_s;
endpackage

// ---- verification/acs_sequencer_monitor.sv ----
// Purpose: port-level checks of the calibration sequencer
// Assumes: bound to acs_sequencer; one clock domain, synchronous reset
// Notes:   checks assume no new command lands in the middle of a step
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_sequencer_monitor #(
    parameter int SETTLE_CONV = `ACS_SETTLE_CONV
) (
    input logic                  clk,
    input logic                  sys_rst,
    input logic                  mode_wr,
    input logic                  cal_mode_bit2,
    input logic                  cal_mode_bit1,
    input logic                  cal_mode_bit0,
    input acs_pkg::acs_raw_s     raw,
    input logic                  result_read,
    input acs_pkg::acs_coef_wr_s ofs_wr,
    input acs_pkg::acs_coef_wr_s fs_wr,
    input acs_pkg::acs_sel_e     in_sel_ff,
    input logic [2:0]            gain_sel_ff,
    input logic                  filter_rst_ff,
    input acs_pkg::acs_result_s  result_ff,
    input logic                  result_ready_n_ff,
    input logic [23:0]           ofs_coef_ff,
    input logic [23:0]           fs_coef_ff
);
    logic [2:0] code;
    logic       one_shot;
    logic       idle_ana;
    // background code is left out: a repeat of it is not taken
    assign code     = {cal_mode_bit2, cal_mode_bit1, cal_mode_bit0};
    assign one_shot = mode_wr && code >= `ACS_CODE_SELF && code <= `ACS_CODE_SYS_OFS;
    assign idle_ana = !mode_wr && in_sel_ff == acs_pkg::SEL_ANALOG;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_cal_cmd;  one_shot; endsequence
    sequence s_self_cmd; mode_wr && code == `ACS_CODE_SELF; endsequence
    sequence s_zero_done; in_sel_ff == acs_pkg::SEL_SHORT && raw.valid && !mode_wr; endsequence

    cmd_busy_a: assert property (s_cal_cmd |=> result_ready_n_ff)
        else $error("ready low after a command");
    cmd_flush_a: assert property (s_cal_cmd |=> filter_rst_ff)
        else $error("no filter reset");
    self_short_a: assert property (s_self_cmd |-> ##2 in_sel_ff == acs_pkg::SEL_SHORT)
        else $error("shorted node not selected");
    short_ref_a: assert property (s_zero_done |-> ##[1:3] in_sel_ff == acs_pkg::SEL_REF)
        else $error("reference not selected");
    ready_cause_a: assert property ($fell(result_ready_n_ff) |-> $past(raw.valid))
        else $error("ready fell without a result");
    result_cause_a: assert property (!$stable(result_ff) |-> $past(raw.valid))
        else $error("result moved without a result");
    gain_hold_a: assert property (in_sel_ff != acs_pkg::SEL_ANALOG |-> $stable(gain_sel_ff))
        else $error("gain moved in calibration");
    unused_code_a: assert property (mode_wr && code[2:1] == 2'h3 && !raw.valid && !ofs_wr.wr
        && !fs_wr.wr |=> !filter_rst_ff && $stable(ofs_coef_ff) && $stable(fs_coef_ff))
        else $error("unassigned code acted");
    ofs_load_a: assert property (ofs_wr.wr && idle_ana |=> ofs_coef_ff == $past(ofs_wr.data))
        else $error("offset write lost");
    fs_load_a: assert property (fs_wr.wr && idle_ana |=> fs_coef_ff == $past(fs_wr.data))
        else $error("full-scale write lost");
    read_clear_a: assert property (result_read && !raw.valid && !mode_wr |=> result_ready_n_ff)
        else $error("ready low after a read");
endmodule

bind acs_sequencer acs_sequencer_monitor #(.SETTLE_CONV(SETTLE_CONV)) i_mon (
    .clk(clk), .sys_rst(sys_rst), .mode_wr(mode_wr), .cal_mode_bit2(cal_mode_bit2),
    .cal_mode_bit1(cal_mode_bit1), .cal_mode_bit0(cal_mode_bit0), .raw(raw),
    .result_read(result_read), .ofs_wr(ofs_wr), .fs_wr(fs_wr), .in_sel_ff(in_sel_ff),
    .gain_sel_ff(gain_sel_ff), .filter_rst_ff(filter_rst_ff), .result_ff(result_ff),
    .result_ready_n_ff(result_ready_n_ff), .ofs_coef_ff(ofs_coef_ff), .fs_coef_ff(fs_coef_ff));

// ---- verification/acs_filter_model.sv ----
// Purpose: behavioural decimation filter feeding the sequencer
// Assumes: one result every LAT+1 cycles, restarted by each filter reset
// Notes:   data toggles between results so a stale word never matches
`timescale 1ns/1ps

module acs_filter_model #(
    parameter int LAT = 64
) (
    input  logic               clk,
    input  logic               sys_rst,
    input  acs_pkg::acs_sel_e  in_sel_ff,
    input  logic               filter_rst_ff,
    input  logic signed [23:0] ana,
    output acs_pkg::acs_raw_s  raw
);
    localparam logic signed [23:0] SHORT_VAL = 24'shE00000;
    localparam logic signed [23:0] REF_VAL   = 24'sh600000;
    int                cnt_ff;
    acs_pkg::acs_raw_s raw_ff;
    assign raw = raw_ff;
    // a filter reset restarts the count
    always_ff @(posedge clk) begin
        if (sys_rst || filter_rst_ff) begin
            cnt_ff <= LAT;
            raw_ff <= '{1'b0, 24'sh5A5A5A};
        end else if (cnt_ff == 0) begin
            cnt_ff       <= LAT;
            raw_ff.valid <= 1'b1;
            raw_ff.data  <= (in_sel_ff == acs_pkg::SEL_SHORT) ? SHORT_VAL :
                            (in_sel_ff == acs_pkg::SEL_REF) ? REF_VAL : ana;
        end else begin
            cnt_ff       <= cnt_ff - 1;
            raw_ff.valid <= 1'b0;
            raw_ff.data  <= ~raw_ff.data;
        end
    end
endmodule

// ---- verification/acs_sequencer_tb.sv ----
// Purpose: directed bench of the calibration sequencer
// Assumes: filter model: shorted node -0x200000, reference +0x600000
// Notes:   a short settle count keeps each calibration brief
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_sequencer_tb;
    localparam int LIMIT = 30000;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  mode_wr = 1'b0;
    logic [2:0]            code = 3'h0;
    logic                  bipolar = 1'b0;
    logic                  long_word = 1'b1;
    logic [2:0]            pga_gain = 3'h0;
    logic                  result_read = 1'b0;
    logic signed [23:0]    ana = 24'sh000000;
    acs_pkg::acs_coef_wr_s ofs_wr = '0;
    acs_pkg::acs_coef_wr_s fs_wr = '0;
    acs_pkg::acs_raw_s     raw;
    acs_pkg::acs_sel_e     in_sel_ff;
    logic [2:0]            gain_sel_ff;
    logic                  filter_rst_ff;
    acs_pkg::acs_result_s  result_ff;
    logic                  result_ready_n_ff;
    logic [23:0]           ofs_coef_ff;
    logic [23:0]           fs_coef_ff;
    logic [2:0]            unused [3] = '{3'h0, 3'h6, 3'h7};
    int                    n_mismatch = 0;
    int                    n_checks = 0;
    int                    cycles = 0;
    int                    n_raw = 0;
    int                    mark = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    acs_sequencer #(.SETTLE_CONV(2)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .mode_wr(mode_wr), .cal_mode_bit2(code[2]),
        .cal_mode_bit1(code[1]), .cal_mode_bit0(code[0]), .bipolar(bipolar),
        .long_word(long_word), .pga_gain(pga_gain), .raw(raw), .result_read(result_read),
        .ofs_wr(ofs_wr), .fs_wr(fs_wr), .in_sel_ff(in_sel_ff), .gain_sel_ff(gain_sel_ff),
        .filter_rst_ff(filter_rst_ff), .result_ff(result_ff),
        .result_ready_n_ff(result_ready_n_ff), .ofs_coef_ff(ofs_coef_ff),
        .fs_coef_ff(fs_coef_ff));

    acs_filter_model #(.LAT(64)) i_flt (
        .clk(clk), .sys_rst(sys_rst), .in_sel_ff(in_sel_ff), .filter_rst_ff(filter_rst_ff),
        .ana(ana), .raw(raw));

    // hang guard and filter result counter
    always @(posedge clk) begin
        cycles++;
        if (raw.valid === 1'b1) n_raw++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            $display("BAD %0t timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic set_mode(input logic [2:0] c);
        code = c;
        mode_wr = 1'b1;
        tick(1);
        mode_wr = 1'b0;
    endtask

    task automatic pulse_read();
        result_read = 1'b1;
        tick(1);
        result_read = 1'b0;
    endtask

    task automatic wait_ready();
        int k;
        for (k = 0; k < 3000 && result_ready_n_ff !== 1'b0; k++) tick(1);
        if (k >= 3000) begin
            n_mismatch++;
            $display("BAD %0t no result", $time);
        end
    endtask

    // ready trusted only a cycle after the command
    task automatic cal(input logic [2:0] c);
        set_mode(c);
        tick(1);
        chk_bit(result_ready_n_ff, 1'b1, "busy");
        wait_ready();
    endtask

    task automatic conv(input logic signed [23:0] a, input logic [23:0] exp);
        ana = a;
        pulse_read();
        wait_ready();
        chk_val(result_ff.data, exp, "result");
    endtask

    // reset, calibrations, host coefficients, background
    initial begin
        tick(8);
        chk_val(ofs_coef_ff, `ACS_OFS_RST, "ofs reset");
        chk_val(fs_coef_ff, `ACS_FS_RST, "fs reset");
        chk_bit(result_ready_n_ff, 1'b1, "ready reset");
        sys_rst = 1'b0;
        conv(24'sh001000, 24'h001000);
        pga_gain = 3'h5;
        ana = 24'shE01000;
        cal(`ACS_CODE_SELF);
        chk_val(ofs_coef_ff, 24'hE00000, "ofs");
        chk_val(fs_coef_ff, 24'h800000, "fs");
        chk_val(result_ff.data, 24'h002000, "result");
        chk_val({21'h0, gain_sel_ff}, 24'h000005, "gain");
        bipolar = 1'b1;
        pulse_read();
        cal(`ACS_CODE_SELF);
        chk_val(fs_coef_ff, 24'h400000, "fs");
        chk_val(result_ff.data, 24'h801000, "result");
        ana = 24'sh000200;
        cal(`ACS_CODE_SYS_ZERO);
        chk_val(ofs_coef_ff, 24'h000200, "ofs");
        chk_val(fs_coef_ff, 24'h400000, "fs");
        ana = 24'sh400200;
        cal(`ACS_CODE_SYS_FULL);
        chk_val(fs_coef_ff, 24'h800000, "fs");
        chk_val(result_ff.data, 24'hFFFFFF, "clamp");
        ana = 24'sh000300;
        cal(`ACS_CODE_SYS_ZERO);
        chk_val(ofs_coef_ff, 24'h000300, "ofs");
        chk_val(fs_coef_ff, 24'h800000, "fs");
        bipolar = 1'b0;
        ana = 24'shE00000;
        cal(`ACS_CODE_SYS_OFS);
        chk_val(ofs_coef_ff, 24'hE00000, "ofs");
        chk_val(fs_coef_ff, 24'h800000, "fs");
        chk_val(result_ff.data, 24'h000000, "result");
        ofs_wr = '{1'b1, 24'h000100};
        fs_wr = '{1'b1, 24'h200000};
        tick(1);
        ofs_wr.wr = 1'b0;
        fs_wr.wr = 1'b0;
        chk_val(ofs_coef_ff, 24'h000100, "ofs wr");
        conv(24'sh002100, 24'h001000);
        for (int i = 0; i < 3; i++) begin
            set_mode(unused[i]);
            tick(2);
            chk_val(ofs_coef_ff, 24'h000100, "ofs kept");
            chk_val(fs_coef_ff, 24'h200000, "fs kept");
        end
        ana = 24'shE00800;
        cal(`ACS_CODE_BACKGND);
        chk_bit(result_ff.stale, 1'b1, "stale 1");
        set_mode(`ACS_CODE_BACKGND);
        pulse_read();
        mark = n_raw;
        wait_ready();
        chk_val(24'(n_raw - mark), 24'h000006, "bg rate");
        chk_bit(result_ff.stale, 1'b0, "stale 2");
        chk_val(result_ff.data, 24'h001000, "bg result");
        set_mode(`ACS_CODE_NORMAL);
        pulse_read();
        wait_ready();
        long_word = 1'b0;
        pulse_read();
        mark = n_raw;
        wait_ready();
        chk_val(24'(n_raw - mark), 24'h000001, "idle rate");
        chk_val(result_ff.data, 24'h000010, "short word");
        test_done();
    end
endmodule
